/* pvr_host.sv */
`timescale 1ns/1ps

module pvr_host
(
    // Clock.
    input wire logic clk,
    // Register strobes, address and write data toward the device.
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [5:0] reg_addr,
    output logic [23:0] reg_wdata
);
    // --------------------
    // Idle values.
    // --------------------
    initial
    begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 24'h000000;
    end

    // --------------------
    // Transfers.
    // --------------------
    task wr(input logic [5:0] a, input logic [23:0] d);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task rd(input logic [5:0] a);
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule

/* pvr_pkg.sv */
package pvr_pkg;

    typedef enum logic {
        PVR_IDLE,
        PVR_FORWARD
    } pvr_fwd_state_t;

    typedef logic [8:0] pvr_vco_word_t;

endpackage

/* pvr_regs.sv */
`timescale 1ns/1ps
`include "pvr_regs.svh"

module pvr_regs
    import pvr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Register port from the serial interface.
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [5:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    output logic [23:0] reg_rdata,
    output logic reg_rdata_valid,
    // Status from the analog and calibration logic.
    input wire logic [18:0] cal_search_error_magnitude_in,
    input wire logic cal_search_error_polarity_in,
    input wire logic gpo_state_in,
    input wire logic lock_detect_in,
    input wire logic [15:0] self_test_signature_in,
    input wire logic self_test_busy_in,
    // Block enables derived by the divider logic in automatic mode.
    input wire logic [3:0] auto_block_enables,
    // VCO controls.
    output logic vco_cal_voltage_sel,
    output logic [7:0] oscillator_subband_select,
    output logic manual_output_enable_mode,
    output logic vco_master_on,
    output logic pll_buffer_en,
    output logic rf_buffer_en,
    output logic div1_en,
    output logic rf_divider_en
);

    // ------------------------------------------------------------------------
    // Status synchronisers.
    // ------------------------------------------------------------------------
    logic [18:0] cal_search_error_magnitude;
    logic cal_search_error_polarity;
    logic gpo_state;
    logic lock_detect;
    logic [15:0] self_test_signature;
    logic self_test_busy;

    pvr_sync #(.W(20), .RESET_VAL({1'b0, `PVR_SEARCH_MAG_RESET})) u_sync_search
    (
        .clk(clk),
        .reset_n(reset_n),
        .async_in({cal_search_error_polarity_in, cal_search_error_magnitude_in}),
        .q({cal_search_error_polarity, cal_search_error_magnitude})
    );

    pvr_sync #(.W(2), .RESET_VAL(2'h0)) u_sync_status
    (
        .clk(clk),
        .reset_n(reset_n),
        .async_in({lock_detect_in, gpo_state_in}),
        .q({lock_detect, gpo_state})
    );

    pvr_sync #(.W(17), .RESET_VAL({1'b0, `PVR_SIGNATURE_RESET})) u_sync_self_test
    (
        .clk(clk),
        .reset_n(reset_n),
        .async_in({self_test_busy_in, self_test_signature_in}),
        .q({self_test_busy, self_test_signature})
    );

    // ------------------------------------------------------------------------
    // Read path.
    // ------------------------------------------------------------------------
    logic [23:0] next_rdata;
    logic next_rdata_valid;

    always_comb
    begin
        next_rdata = 24'h000000;
        next_rdata_valid = reg_rd_en;
        if (reg_rd_en)
        begin
            case (reg_addr)
                `PVR_ADDR_SEARCH_ERR:
                begin
                    next_rdata[18:0] = cal_search_error_magnitude;
                    next_rdata[`PVR_SE_SIGN_BIT] = cal_search_error_polarity;
                end
                `PVR_ADDR_STATUS:
                begin
                    next_rdata[`PVR_ST_GPO_BIT] = gpo_state;
                    next_rdata[`PVR_ST_LOCK_BIT] = lock_detect;
                end
                `PVR_ADDR_SELF_TEST:
                begin
                    next_rdata[15:0] = self_test_signature;
                    next_rdata[`PVR_BIST_BUSY_BIT] = self_test_busy;
                end
                default:
                begin
                    next_rdata = 24'h000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata <= 24'h000000;
            reg_rdata_valid <= 1'b0;
        end
        else
        begin
            reg_rdata <= next_rdata;
            reg_rdata_valid <= next_rdata_valid;
        end
    end

    // ------------------------------------------------------------------------
    // Indirect port capture and forwarding.
    // ------------------------------------------------------------------------
    pvr_fwd_state_t state;
    pvr_fwd_state_t next_state;
    logic [2:0] pend_id;
    logic [3:0] pend_addr;
    pvr_vco_word_t pend_data;
    logic [2:0] next_pend_id;
    logic [3:0] next_pend_addr;
    pvr_vco_word_t next_pend_data;
    pvr_vco_word_t tuning;
    pvr_vco_word_t enables;
    pvr_vco_word_t config_word;
    pvr_vco_word_t next_tuning;
    pvr_vco_word_t next_enables;
    pvr_vco_word_t next_config_word;
    logic ind_write;

    assign ind_write = reg_wr_en && (reg_addr == `PVR_ADDR_INDIRECT);

    always_comb
    begin
        next_state = state;
        next_pend_id = pend_id;
        next_pend_addr = pend_addr;
        next_pend_data = pend_data;
        next_tuning = tuning;
        next_enables = enables;
        next_config_word = config_word;
        case (state)
            PVR_IDLE:
            begin
                next_state = PVR_IDLE;
            end
            PVR_FORWARD:
            begin
                next_state = PVR_IDLE;
                if (pend_id == `PVR_SUBSYS_VCO)
                begin
                    case (pend_addr)
                        `PVR_VCO_TUNING: next_tuning = pend_data;
                        `PVR_VCO_ENABLES: next_enables = pend_data;
                        `PVR_VCO_CONFIG: next_config_word = pend_data;
                        default: next_tuning = tuning;
                    endcase
                end
            end
            default:
            begin
                next_state = PVR_IDLE;
            end
        endcase
        if (ind_write)
        begin
            next_state = PVR_FORWARD;
            next_pend_id = reg_wdata[`PVR_IND_ID_MSB:`PVR_IND_ID_LSB];
            next_pend_addr = reg_wdata[`PVR_IND_ADDR_MSB:`PVR_IND_ADDR_LSB];
            next_pend_data = reg_wdata[`PVR_IND_DATA_MSB:`PVR_IND_DATA_LSB];
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= PVR_IDLE;
            pend_id <= 3'h0;
            pend_addr <= 4'h0;
            pend_data <= 9'h000;
            tuning <= `PVR_TUNING_RESET;
            enables <= `PVR_ENABLES_RESET;
            config_word <= `PVR_CONFIG_RESET;
        end
        else
        begin
            state <= next_state;
            pend_id <= next_pend_id;
            pend_addr <= next_pend_addr;
            pend_data <= next_pend_data;
            tuning <= next_tuning;
            enables <= next_enables;
            config_word <= next_config_word;
        end
    end

    // ------------------------------------------------------------------------
    // VCO tuning, mode and master enable controls.
    // ------------------------------------------------------------------------
    assign vco_cal_voltage_sel = tuning[`PVR_TUN_CAL_BIT];
    assign oscillator_subband_select = tuning[`PVR_TUN_BAND_MSB:`PVR_TUN_BAND_LSB];
    assign manual_output_enable_mode = config_word[`PVR_CFG_MANUAL_BIT];
    assign vco_master_on = enables[`PVR_EN_MASTER_BIT];

    // ------------------------------------------------------------------------
    // Block enables.
    // ------------------------------------------------------------------------
    logic [3:0] blocks;
    logic [3:0] next_blocks;

    always_comb
    begin
        if (!enables[`PVR_EN_MASTER_BIT])
        begin
            next_blocks = 4'h0;
        end
        else if (config_word[`PVR_CFG_MANUAL_BIT])
        begin
            next_blocks = enables[`PVR_EN_LOCAL_MSB:`PVR_EN_LOCAL_LSB];
        end
        else
        begin
            next_blocks = auto_block_enables;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            blocks <= 4'h0;
        end
        else
        begin
            blocks <= next_blocks;
        end
    end

    assign {rf_divider_en, div1_en, rf_buffer_en, pll_buffer_en} = blocks;

    // ------------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------------
    search_err_read_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (reg_rd_en && reg_addr == `PVR_ADDR_SEARCH_ERR)
        |=> (reg_rdata == {4'h0, $past(cal_search_error_polarity),
                           $past(cal_search_error_magnitude)}) && reg_rdata_valid)
        else $error("Search error read returned wrong value.");

    search_sign_read_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (reg_rd_en && reg_addr == `PVR_ADDR_SEARCH_ERR && cal_search_error_polarity)
        |=> reg_rdata[19])
        else $error("Search error sign not reported.");

    status_read_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (reg_rd_en && reg_addr == `PVR_ADDR_STATUS)
        |=> reg_rdata == {22'h000000, $past(lock_detect), $past(gpo_state)})
        else $error("Status read returned wrong value.");

    self_test_read_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (reg_rd_en && reg_addr == `PVR_ADDR_SELF_TEST)
        |=> reg_rdata == {7'h00, $past(self_test_busy), $past(self_test_signature)})
        else $error("Self-test read returned wrong value.");

    no_direct_write_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state == PVR_IDLE && !ind_write) |=> $stable(tuning) && $stable(enables))
        else $error("VCO register changed without indirect write.");

    tuning_forward_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (ind_write && reg_wdata[6:0] == 7'h00) ##1 !ind_write
        |=> (tuning == $past(reg_wdata[15:7], 2))
            && (vco_cal_voltage_sel == $past(reg_wdata[7], 2)))
        else $error("Tuning write not forwarded in two cycles.");

    master_off_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        !enables[0] |=> blocks == 4'h0)
        else $error("Blocks enabled while master enable low.");

    manual_and_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (enables[0] && config_word[2]) |=> blocks == $past(enables[4:1]))
        else $error("Manual mode enables not gated by local bits.");

    auto_mode_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (enables[0] && !config_word[2]) |=> blocks == $past(auto_block_enables))
        else $error("Automatic mode did not ignore local enables.");

    mute_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (ind_write && reg_wdata[15:0] == 16'h0D88) ##1 !ind_write ##1 config_word[2]
        |=> !rf_buffer_en && pll_buffer_en && div1_en && rf_divider_en)
        else $error("Mute write did not clear only the RF buffer.");

endmodule

/* pvr_regs.svh */
`ifndef PVR_REGS_SVH
`define PVR_REGS_SVH

// ----------------------------------------------------------------------------
// Main map offsets.
// ----------------------------------------------------------------------------
`define PVR_ADDR_INDIRECT 6'h05
`define PVR_ADDR_SEARCH_ERR 6'h11
`define PVR_ADDR_STATUS 6'h12
`define PVR_ADDR_SELF_TEST 6'h13

// ----------------------------------------------------------------------------
// Indirect access register fields.
// ----------------------------------------------------------------------------
`define PVR_IND_ID_MSB 2
`define PVR_IND_ID_LSB 0
`define PVR_IND_ADDR_MSB 6
`define PVR_IND_ADDR_LSB 3
`define PVR_IND_DATA_MSB 15
`define PVR_IND_DATA_LSB 7

// ----------------------------------------------------------------------------
// VCO subsystem identifier and register indices.
// ----------------------------------------------------------------------------
`define PVR_SUBSYS_VCO 3'h0
`define PVR_VCO_TUNING 4'h0
`define PVR_VCO_ENABLES 4'h1
`define PVR_VCO_CONFIG 4'h3

// ----------------------------------------------------------------------------
// VCO register fields.
// ----------------------------------------------------------------------------
`define PVR_TUN_CAL_BIT 0
`define PVR_TUN_BAND_MSB 8
`define PVR_TUN_BAND_LSB 1
`define PVR_EN_MASTER_BIT 0
`define PVR_EN_LOCAL_MSB 4
`define PVR_EN_LOCAL_LSB 1
`define PVR_CFG_MANUAL_BIT 2

// ----------------------------------------------------------------------------
// Status register fields.
// ----------------------------------------------------------------------------
`define PVR_SE_SIGN_BIT 19
`define PVR_ST_GPO_BIT 0
`define PVR_ST_LOCK_BIT 1
`define PVR_BIST_BUSY_BIT 16

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define PVR_SEARCH_MAG_RESET 19'h7FFFF
`define PVR_SIGNATURE_RESET 16'h1259
`define PVR_TUNING_RESET 9'h020
`define PVR_ENABLES_RESET 9'h01F
`define PVR_CONFIG_RESET 9'h051

`endif

/* pvr_sync.sv */
`timescale 1ns/1ps

module pvr_sync
    import pvr_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Asynchronous input and accepted value.
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] q
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    // A bit is accepted once the second and third stages agree.
    always_comb
    begin
        next_q = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & q);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
            q <= RESET_VAL;
        end
        else
        begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            q <= next_q;
        end
    end

endmodule

/* tb_pvr_regs.sv */
`timescale 1ns/1ps
`include "pvr_regs.svh"

module tb_pvr_regs;
    // --------------------
    // Signals.
    // --------------------
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic reg_wr_en, reg_rd_en, reg_rdata_valid;
    logic [5:0] reg_addr;
    logic [23:0] reg_wdata, reg_rdata;
    logic [18:0] mag = 19'h7FFFF;
    logic sign = 1'b0;
    logic gpo = 1'b0;
    logic lock = 1'b0;
    logic [15:0] sig = 16'h1259;
    logic busy = 1'b0;
    logic [3:0] auto_en = 4'h0;
    logic cal_sel, manual, master, pll_en, rfb_en, d1_en, rfd_en;
    logic [7:0] band;
    logic [8:0] m_tun = 9'h020;
    logic [8:0] m_en = 9'h01F;
    logic [8:0] m_cfg = 9'h051;
    logic [31:0] seed = 32'h000005FA;
    logic [31:0] r;
    logic [23:0] rd_q[$];
    int fails = 0;
    int comparisons = 0;

    always #50 clk = ~clk;

    pvr_host i_host (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    pvr_regs i_dut (.clk(clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
        .cal_search_error_magnitude_in(mag), .cal_search_error_polarity_in(sign),
        .gpo_state_in(gpo), .lock_detect_in(lock), .self_test_signature_in(sig),
        .self_test_busy_in(busy), .auto_block_enables(auto_en),
        .vco_cal_voltage_sel(cal_sel), .oscillator_subband_select(band),
        .manual_output_enable_mode(manual), .vco_master_on(master),
        .pll_buffer_en(pll_en), .rf_buffer_en(rfb_en), .div1_en(d1_en),
        .rf_divider_en(rfd_en));

    // --------------------
    // Helpers.
    // --------------------
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function logic [14:0] exp_ctl();
        logic [3:0] be;
        be = !m_en[0] ? 4'h0 : (m_cfg[2] ? m_en[4:1] : auto_en);
        return {m_tun[0], m_tun[8:1], m_cfg[2], m_en[0], be};
    endfunction

    task chk_rd(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: read got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_ctl(input logic [14:0] got, input logic [14:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: controls got %h expected %h", $time, got, exp);
        end
    endtask

    task ctl();
        @(negedge clk);
        chk_ctl({cal_sel, band, manual, master, rfd_en, d1_en, rfb_en, pll_en}, exp_ctl());
    endtask

    task rd(input logic [5:0] a, input logic [23:0] e);
        rd_q.push_back(e);
        i_host.rd(a);
    endtask

    task wr_vco(input logic [2:0] id, input logic [3:0] a, input logic [8:0] d);
        i_host.wr(`PVR_ADDR_INDIRECT, {8'h00, d, a, id});
        if (id == `PVR_SUBSYS_VCO && a == `PVR_VCO_TUNING)
            m_tun = d;
        if (id == `PVR_SUBSYS_VCO && a == `PVR_VCO_ENABLES)
            m_en = d;
        if (id == `PVR_SUBSYS_VCO && a == `PVR_VCO_CONFIG)
            m_cfg = d;
        repeat (4) @(posedge clk);
    endtask

    task set_st();
        r = rnd();
        @(posedge clk);
        mag <= r[18:0];
        sign <= r[19];
        gpo <= r[20];
        lock <= r[21];
        sig <= r[31:16];
        busy <= r[22];
        repeat (6) @(posedge clk);
    endtask

    task results();
        if (rd_q.size() != 0)
            fails++;
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // --------------------
    // Read result monitor.
    // --------------------
    always @(negedge clk)
    begin
        if (reg_rdata_valid === 1'b1)
        begin
            if (rd_q.size() == 0)
                chk_rd({23'h0, reg_rdata_valid}, 24'h000000);
            else
                chk_rd(reg_rdata, rd_q.pop_front());
        end
    end

    // --------------------
    // Tests.
    // --------------------
    initial
    begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        ctl();
        rd(`PVR_ADDR_SEARCH_ERR, 24'h07FFFF);
        rd(`PVR_ADDR_STATUS, 24'h000000);
        rd(`PVR_ADDR_SELF_TEST, 24'h001259);
        $display("Test reset values done");
        repeat (4)
        begin
            set_st();
            rd(`PVR_ADDR_SEARCH_ERR, {4'h0, sign, mag});
            rd(`PVR_ADDR_STATUS, {22'h000000, lock, gpo});
            rd(`PVR_ADDR_SELF_TEST, {7'h00, busy, sig});
            rd(`PVR_ADDR_INDIRECT, 24'h000000);
        end
        $display("Test status reads done");
        repeat (3)
        begin
            r = rnd();
            wr_vco(`PVR_SUBSYS_VCO, `PVR_VCO_TUNING, r[8:0]);
            ctl();
            wr_vco(3'h1, `PVR_VCO_TUNING, ~r[8:0]);
            ctl();
            wr_vco(`PVR_SUBSYS_VCO, 4'h2, ~r[8:0]);
            ctl();
        end
        $display("Test tuning done");
        repeat (6)
        begin
            r = rnd();
            @(posedge clk);
            auto_en <= r[3:0];
            wr_vco(`PVR_SUBSYS_VCO, `PVR_VCO_ENABLES, {4'h0, r[7:4], r[8]});
            ctl();
        end
        wr_vco(`PVR_SUBSYS_VCO, `PVR_VCO_ENABLES, 9'h01E);
        ctl();
        $display("Test automatic mode done");
        wr_vco(`PVR_SUBSYS_VCO, `PVR_VCO_CONFIG, 9'h055);
        ctl();
        wr_vco(`PVR_SUBSYS_VCO, `PVR_VCO_ENABLES, 9'h01B);
        ctl();
        for (int i = 0; i < 5; i++)
        begin
            wr_vco(`PVR_SUBSYS_VCO, `PVR_VCO_ENABLES, 9'h01F ^ (9'h001 << i));
            ctl();
        end
        wr_vco(`PVR_SUBSYS_VCO, `PVR_VCO_CONFIG, 9'h051);
        ctl();
        $display("Test manual mode done");
        results();
    end

    initial
    begin
        #1000000;
        fails++;
        results();
    end
endmodule
